// ---- logic/art_top.sv ----
// What this block does
// - Completed 10-bit result lands in read-only result pair, reset zero.
// - Reading low byte freezes result pair until high byte is read.
// - Justify clear: bits 9:8 in high 1:0, low holds 7:0.
// - Justify set (bit 3): high holds 9:2, low 7:6 holds 1:0.
// - Justify changes alter presented layout immediately.
// - Trigger source field matters only while auto-trigger is enabled.
// - Source codes: free, comparator, ext int0, t0 cmpA, t0 ovf, t1 cmpB, t1 ovf, t1 cap.
// - Auto-trigger starts conversion on rising edge of selected flag.
// - Switching from clear source to set source counts as rising edge.
// - Selecting free running does not itself trigger.
// - Disable bit forces matching port input bit to zero.
// - Disable 0: bits 7:3 channels 4..0, bits 2:1 comparator, bit 0 reference.
// - Disable 1: bits 3:0 channels 8..5; bits 7:4 read zero.
// - Disable 2: bits 2:0 channels 11..9.
// - Done flag sets whenever conversion finishes, even while a frozen result pair is not updated.
//
// Chosen here: the plain strobed port.
`include "art_map.svh"
module art_top (
	// Clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	input  wire logic               ce_in,
	// Register port
	input  wire logic [7:0]         addr_in,
	input  wire logic [7:0]         wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [7:0]         rdata_out,
	// Converter core
	input  wire logic               conv_done_in,
	input  wire logic [9:0]         conv_result_in,
	output logic                    conv_start_out,
	output logic                    conv_on_out,
	// Trigger flags, index is the source code
	input  wire logic [7:0]         trig_flags_in,
	// Pins: 12 channels, two comparator inputs, reference
	input  wire logic [11:0]        chan_pin_in,
	input  wire logic [1:0]         comp_pin_in,
	input  wire logic               ref_pin_in,
	output logic      [11:0]        chan_port_out,
	output logic      [1:0]         comp_port_out,
	output logic                    ref_port_out,
	output logic      [14:0]        buf_off_out,
	// Interrupt
	output logic                    irq_out
);
	import art_pkg::*;

	logic [9:0]  result_q;
	art_lock_t   lock_q;
	logic [7:0]  ctrl_b_q;
	logic [7:0]  ctrl_a_q;
	logic [7:0]  dis0_q;
	logic [7:0]  dis1_q;
	logic [7:0]  dis2_q;
	logic [7:0]  int_stat_q;
	logic [7:0]  int_mask_q;
	logic        trig_prev_q;
	logic        trig_now;
	logic        trig_edge;
	logic        wr_ctrl_a;
	logic        rd_lo;
	logic        rd_hi;
	logic        rd_stat;
	logic        justify;
	logic        auto_on;
	logic [7:0]  rdata_d;
	art_tsel_t   tsel;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign justify   = ctrl_b_q[`ART_CTRLB_JUSTIFY];
	assign auto_on   = ctrl_a_q[`ART_CTRLA_AUTO_ON];
	assign tsel      = art_tsel_t'(ctrl_b_q[`ART_CTRLB_TSEL_LO +: 3]);
	assign wr_ctrl_a = wr_in && hit(addr_in, `ART_OFF_CTRL_A);
	assign rd_lo     = rd_in && hit(addr_in, `ART_OFF_RES_LO);
	assign rd_hi     = rd_in && hit(addr_in, `ART_OFF_RES_HI);
	assign rd_stat   = rd_in && hit(addr_in, `ART_OFF_INT_STAT);

	// free running has no flag edge
	always_comb begin
		if (tsel == ART_TS_FREE) begin
			trig_now = 1'b0;
		end else begin
			trig_now = trig_flags_in[tsel];
		end
	end

	assign trig_edge = trig_now && !trig_prev_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_prev_q <= 1'b0;
		end else if (ce_in) begin
			trig_prev_q <= trig_now;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			conv_start_out <= 1'b0;
		end else if (ce_in) begin
			if (tsel == ART_TS_FREE) begin
				// Free running restarts on each completion once auto-trigger and the converter enable are both on.
				conv_start_out <= auto_on && ctrl_a_q[`ART_CTRLA_CONV_ON] && conv_done_in;
			end else begin
				conv_start_out <= auto_on && ctrl_a_q[`ART_CTRLA_CONV_ON] && trig_edge;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lock_q <= ART_UNLOCKED;
		end else if (ce_in) begin
			if (rd_hi) begin
				lock_q <= ART_UNLOCKED;
			end else if (rd_lo) begin
				lock_q <= ART_LOCKED;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			result_q <= 10'h000;
		end else if (ce_in) begin
			if (conv_done_in && lock_q == ART_UNLOCKED && !rd_lo) begin
				result_q <= conv_result_in;
			end
		end
	end

	// done flag set wins over clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_a_q <= `ART_RESET_BYTE;
		end else if (ce_in) begin
			if (wr_ctrl_a) begin
				ctrl_a_q[7:5] <= wdata_in[7:5] & 3'(`ART_CTRLA_WMASK >> 5);
			end
			if (conv_done_in) begin
				ctrl_a_q[`ART_CTRLA_DONE] <= 1'b1;
			end else if (wr_ctrl_a && wdata_in[`ART_CTRLA_DONE]) begin
				ctrl_a_q[`ART_CTRLA_DONE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_b_q <= `ART_RESET_BYTE;
		end else if (ce_in && wr_in && hit(addr_in, `ART_OFF_CTRL_B)) begin
			ctrl_b_q <= wdata_in & `ART_CTRLB_WMASK;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dis0_q <= `ART_RESET_BYTE;
			dis1_q <= `ART_RESET_BYTE;
			dis2_q <= `ART_RESET_BYTE;
		end else if (ce_in && wr_in) begin
			if (hit(addr_in, `ART_OFF_DIS_0)) begin
				dis0_q <= wdata_in;
			end
			if (hit(addr_in, `ART_OFF_DIS_1)) begin
				dis1_q <= wdata_in & `ART_DIS1_WMASK;
			end
			if (hit(addr_in, `ART_OFF_DIS_2)) begin
				dis2_q <= wdata_in & `ART_DIS2_WMASK;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chan_port_out <= 12'h000;
			comp_port_out <= 2'h0;
			ref_port_out  <= 1'b0;
			buf_off_out   <= 15'h0000;
		end else if (ce_in) begin
			chan_port_out <= chan_pin_in & ~{dis2_q[2:0], dis1_q[3:0], dis0_q[7:3]};
			comp_port_out <= comp_pin_in & ~dis0_q[2:1];
			ref_port_out  <= ref_pin_in & ~dis0_q[0];
			buf_off_out   <= {dis2_q[2:0], dis1_q[3:0], dis0_q};
		end
	end

	// Interrupt status: done, trigger, lost result. Set wins over read-clear.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_stat_q <= `ART_RESET_BYTE;
			int_mask_q <= `ART_RESET_BYTE;
			irq_out    <= 1'b0;
		end else if (ce_in) begin
			int_stat_q <= (rd_stat ? 8'h00 : int_stat_q) | {5'h00,
				conv_done_in && lock_q == ART_LOCKED, auto_on && trig_edge, conv_done_in};
			if (wr_in && hit(addr_in, `ART_OFF_INT_MASK)) begin
				int_mask_q <= wdata_in & `ART_INT_WMASK;
			end
			irq_out <= |(int_stat_q & int_mask_q);
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		case (addr_in)
			`ART_OFF_RES_LO:   rdata_d = justify ? {result_q[1:0], 6'h00} : result_q[7:0];
			`ART_OFF_RES_HI:   rdata_d = justify ? result_q[9:2] : {6'h00, result_q[9:8]};
			`ART_OFF_CTRL_B:   rdata_d = ctrl_b_q;
			`ART_OFF_CTRL_A:   rdata_d = ctrl_a_q;
			`ART_OFF_INT_STAT: rdata_d = int_stat_q;
			`ART_OFF_INT_MASK: rdata_d = int_mask_q;
			`ART_OFF_DIS_0:    rdata_d = dis0_q;
			`ART_OFF_DIS_1:    rdata_d = dis1_q;
			`ART_OFF_DIS_2:    rdata_d = dis2_q;
			default:           rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out   <= 8'h00;
			conv_on_out <= 1'b0;
		end else if (ce_in) begin
			rdata_out   <= rd_in ? rdata_d : 8'h00;
			conv_on_out <= ctrl_a_q[`ART_CTRLA_CONV_ON];
		end
	end
endmodule

// ---- logic/art_map.svh ----
`ifndef ART_MAP_SVH
`define ART_MAP_SVH
// Register offsets on the plain register port.
`define ART_OFF_RES_LO   8'h00
`define ART_OFF_RES_HI   8'h01
`define ART_OFF_CTRL_B   8'h02
`define ART_OFF_CTRL_A   8'h03
`define ART_OFF_INT_STAT 8'h04
`define ART_OFF_INT_MASK 8'h05
`define ART_OFF_DIS_0    8'h60
`define ART_OFF_DIS_1    8'h61
`define ART_OFF_DIS_2    8'h62
// Field positions.
`define ART_CTRLB_JUSTIFY 3
`define ART_CTRLB_TSEL_LO 0
`define ART_CTRLA_CONV_ON 7
`define ART_CTRLA_AUTO_ON 5
`define ART_CTRLA_DONE    4
`define ART_INT_DONE      0
`define ART_INT_TRIG      1
`define ART_INT_LOST      2
// Writable masks and reset values.
`define ART_CTRLB_WMASK   8'h0F
`define ART_CTRLA_WMASK   8'hA0
`define ART_INT_WMASK     8'h07
`define ART_DIS1_WMASK    8'h0F
`define ART_DIS2_WMASK    8'h07
`define ART_RESET_BYTE    8'h00
`endif

// ---- logic/art_pkg.sv ----
package art_pkg;
	typedef enum logic [2:0] {
		ART_TS_FREE, ART_TS_COMP, ART_TS_EXT0, ART_TS_T0CMPA,
		ART_TS_T0OVF, ART_TS_T1CMPB, ART_TS_T1OVF, ART_TS_T1CAP
	} art_tsel_t;
	typedef enum logic {
		ART_UNLOCKED, ART_LOCKED
	} art_lock_t;
endpackage

// ---- verif/art_chk.sv ----
`include "art_map.svh"
module art_chk (
	// Clock, reset and enable
	input wire logic        clk_in,
	input wire logic        nrst_in,
	input wire logic        ce_in,
	// Register port
	input wire logic [7:0]  addr_in,
	input wire logic [7:0]  wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rdata_out,
	// Converter, trigger and pins
	input wire logic        conv_done_in,
	input wire logic        conv_start_out,
	input wire logic [7:0]  trig_flags_in,
	input wire logic [11:0] chan_pin_in,
	input wire logic [1:0]  comp_pin_in,
	input wire logic [11:0] chan_port_out,
	input wire logic [1:0]  comp_port_out,
	input wire logic [14:0] buf_off_out,
	input wire logic        irq_out
);
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not zero");
	// Ports and buffer flags are registered in the same cycle; compare only while the flags hold.
	chk_chan_gate: assert property ($stable(buf_off_out) |-> chan_port_out == ($past(chan_pin_in) & ~buf_off_out[14:3]))
		else $error("channel port value wrong");
	chk_comp_gate: assert property ($stable(buf_off_out) |-> comp_port_out == ($past(comp_pin_in) & ~buf_off_out[2:1]))
		else $error("comparator port value wrong");
	chk_start_cause: assert property (conv_start_out |-> $past(conv_done_in || |trig_flags_in[7:1], 1)
		|| $past(conv_done_in || |trig_flags_in[7:1], 2))
		else $error("start without trigger");
	chk_dis0_write: assert property (ce_in && wr_in && addr_in == `ART_OFF_DIS_0 |-> ##2 buf_off_out[7:0] == $past(wdata_in, 2))
		else $error("disable 0 not applied");
	chk_dis1_ro: assert property (rd_in && addr_in == `ART_OFF_DIS_1 |=> rdata_out[7:4] == 4'h0)
		else $error("disable 1 upper bits set");
	chk_dis2_ro: assert property (rd_in && addr_in == `ART_OFF_DIS_2 |=> rdata_out[7:3] == 5'h00)
		else $error("disable 2 upper bits set");
	chk_ctrlb_ro: assert property (rd_in && addr_in == `ART_OFF_CTRL_B |=> rdata_out[7:4] == 4'h0)
		else $error("control b upper bits set");
	cov_start: cover property (conv_start_out);
	cov_irq: cover property ($rose(irq_out));
	cov_high_read: cover property (rd_in && addr_in == `ART_OFF_RES_HI);
endmodule

// ---- verif/tb.sv ----
`include "art_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, nrst_in, ce_in, wr_in, rd_in, conv_done_in, conv_start_out, conv_on_out;
	logic        ref_pin_in, ref_port_out, irq_out;
	logic [7:0]  addr_in, wdata_in, rdata_out, trig_flags_in;
	logic [9:0]  conv_result_in;
	logic [11:0] chan_pin_in, chan_port_out;
	logic [1:0]  comp_pin_in, comp_port_out;
	logic [14:0] buf_off_out;
	logic [7:0]  offs [6] = '{8'h00, 8'h01, 8'h02, 8'h60, 8'h61, 8'h62};
	logic [9:0]  r1 = 10'h2B5;
	int          err_total, n_compared, n;
	art_top art_top_inst (.clk_in, .nrst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.conv_done_in, .conv_result_in, .conv_start_out, .conv_on_out, .trig_flags_in, .chan_pin_in,
		.comp_pin_in, .ref_pin_in, .chan_port_out, .comp_port_out, .ref_port_out, .buf_off_out, .irq_out);
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_in);
		{wr_in, addr_in, wdata_in} <= {1'b1, a, d};
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(string nm, logic [7:0] a, logic [7:0] e);
		@(posedge clk_in);
		{rd_in, addr_in} <= {1'b1, a};
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		cmp(nm, {8'h00, e}, {8'h00, rdata_out});
	endtask
	task automatic done(logic [9:0] r);
		@(posedge clk_in);
		{conv_done_in, conv_result_in} <= {1'b1, r};
		@(posedge clk_in);
		conv_done_in <= 1'b0;
	endtask
	task automatic starts(logic [15:0] e);
		n = 0;
		repeat (6) begin
			@(negedge clk_in);
			n += int'(conv_start_out === 1'b1);
		end
		cmp("start count", e, n[15:0]);
	endtask
	task automatic close_out();
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{ce_in, nrst_in, wr_in, rd_in, conv_done_in} = 5'b10000;
		{addr_in, wdata_in, trig_flags_in, conv_result_in} = '0;
		{chan_pin_in, comp_pin_in, ref_pin_in} = '0;
		err_total = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		foreach (offs[i]) rd("reset value", offs[i], 8'h00);
		rd("unmapped", 8'h10, 8'h00);
		@(posedge clk_in);
		{chan_pin_in, comp_pin_in, ref_pin_in} <= '1;
		wr(`ART_OFF_DIS_1, 8'hFF);
		rd("disable 1", `ART_OFF_DIS_1, 8'h0F);
		wr(`ART_OFF_DIS_2, 8'hFF);
		rd("disable 2", `ART_OFF_DIS_2, 8'h07);
		wr(`ART_OFF_DIS_0, 8'h0A);
		repeat (3) @(negedge clk_in);
		cmp("chan port", 16'h001E, {4'h0, chan_port_out});
		cmp("comp ref port", 16'h0005, {13'h0, comp_port_out, ref_port_out});
		cmp("buffer off", 16'h7F0A, {1'b0, buf_off_out});
		// A write made while the clock enable is low must leave the register alone.
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(`ART_OFF_DIS_0, 8'hFF);
		@(posedge clk_in);
		ce_in <= 1'b1;
		rd("frozen disable 0", `ART_OFF_DIS_0, 8'h0A);
		done(r1);
		rd("low byte", `ART_OFF_RES_LO, r1[7:0]);
		// A result arriving while frozen must be dropped.
		done(10'h3FF);
		rd("high byte", `ART_OFF_RES_HI, {6'h00, r1[9:8]});
		wr(`ART_OFF_CTRL_B, 8'h08);
		rd("left low", `ART_OFF_RES_LO, {r1[1:0], 6'h00});
		rd("left high", `ART_OFF_RES_HI, r1[9:2]);
		wr(`ART_OFF_CTRL_B, 8'h00);
		rd("done flag", `ART_OFF_CTRL_A, 8'h10);
		cmp("irq masked", 16'h0000, {15'h0, irq_out});
		rd("status", `ART_OFF_INT_STAT, 8'h05);
		wr(`ART_OFF_INT_MASK, 8'h01);
		done(10'h155);
		repeat (3) @(negedge clk_in);
		cmp("irq raised", 16'h0001, {15'h0, irq_out});
		rd("status", `ART_OFF_INT_STAT, 8'h01);
		repeat (2) @(negedge clk_in);
		cmp("irq cleared", 16'h0000, {15'h0, irq_out});
		wr(`ART_OFF_CTRL_A, 8'hA0);
		repeat (2) @(negedge clk_in);
		cmp("converter on", 16'h0001, {15'h0, conv_on_out});
		for (int k = 1; k < 8; k++) begin
			wr(`ART_OFF_CTRL_B, 8'(k));
			@(posedge clk_in);
			trig_flags_in <= 8'h01 << k;
			starts(1);
			@(posedge clk_in);
			trig_flags_in <= 8'h00;
		end
		@(posedge clk_in);
		trig_flags_in <= 8'h04;
		starts(0);
		wr(`ART_OFF_CTRL_B, 8'h02);
		starts(1);
		@(posedge clk_in);
		trig_flags_in <= 8'h00;
		wr(`ART_OFF_CTRL_B, 8'h01);
		wr(`ART_OFF_CTRL_B, 8'h00);
		starts(0);
		done(10'h001);
		starts(1);
		wr(`ART_OFF_CTRL_A, 8'h80);
		wr(`ART_OFF_CTRL_B, 8'h03);
		@(posedge clk_in);
		trig_flags_in <= 8'h08;
		starts(0);
		close_out();
	end
	initial begin
		#50us;
		err_total++;
		close_out();
	end
endmodule
bind art_top art_chk art_chk_inst (.clk_in, .nrst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
	.conv_done_in, .conv_start_out, .trig_flags_in, .chan_pin_in, .comp_pin_in, .chan_port_out,
	.comp_port_out, .buf_off_out, .irq_out);
